// ==== rtl/rpr_pkg.sv ====
// package: offsets, reset values, field positions and carrier types for the power/id/ram register group
package rpr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CFG_KEY       = 8'h1F;
    localparam logic [7:0] OFF_BATTERY_IO    = 8'h27;
    localparam logic [7:0] OFF_PART_HIGH     = 8'h28;
    localparam logic [7:0] OFF_PART_LOW      = 8'h29;
    localparam logic [7:0] OFF_REVISION      = 8'h2A;
    localparam logic [7:0] OFF_YEAR_WEEK     = 8'h2B;
    localparam logic [7:0] OFF_WAFER_WEEK    = 8'h2C;
    localparam logic [7:0] OFF_LOT_QUAD      = 8'h2D;
    localparam logic [7:0] OFF_SERIAL        = 8'h2E;
    localparam logic [7:0] OFF_SUPPLY_STATUS = 8'h2F;
    localparam logic [7:0] OFF_INPUT_GATING  = 8'h30;
    localparam logic [7:0] OFF_RAM_PAGE      = 8'h3F;
    localparam logic [7:0] OFF_STD_RAM_LO    = 8'h40;
    localparam logic [7:0] OFF_ALT_RAM_LO    = 8'h80;

    // ------------------------------------------------------------
    // key and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_ANALOG_UNLOCK = 8'h9D;
    localparam logic [7:0] RST_CFG_KEY       = 8'h00;
    localparam logic [7:0] RST_BATTERY_IO    = 8'h80;
    localparam logic [7:0] RST_INPUT_GATING  = 8'h00;
    localparam logic [7:0] RST_RAM_PAGE      = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_KEEP_IF        = 7;
    localparam int BIT_BAT_ABOVE_THR  = 7;
    localparam int BIT_BAT_ABOVE_MIN  = 6;
    localparam int BIT_MAIN_ABOVE_PU  = 1;
    localparam int BIT_KICK_BAT_EN    = 7;
    localparam int BIT_EXT_BAT_EN     = 6;
    localparam int BIT_CLKOUT_BAT_EN  = 7;
    localparam int BIT_BAT_LOW_POL    = 6;
    localparam int BIT_KICK_LEVEL     = 5;
    localparam int BIT_EXT_LEVEL      = 4;
    localparam int BIT_PAGE_ENABLE    = 3;
    localparam int BIT_ALT_PAGE       = 2;
    localparam int STD_PAGE_MSB       = 1;
    localparam int STD_PAGE_LSB       = 0;
    localparam logic [7:0] MASK_BATTERY_IO   = 8'h80;
    localparam logic [7:0] MASK_INPUT_GATING = 8'hC0;
    localparam logic [7:0] MASK_RAM_PAGE_RW  = 8'hCF;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       i2c_mode;
    } rpr_req_t;

    typedef struct packed {
        logic [7:0] part_high;
        logic [7:0] part_low;
        logic [4:0] rev_major;
        logic [2:0] rev_minor;
        logic [3:0] fab_year;
        logic [5:0] fab_week;
        logic [5:0] wafer;
        logic [1:0] lot;
        logic [5:0] quadrant;
        logic [7:0] serial;
    } rpr_ident_t;

    typedef enum logic [1:0] {
        RPR_WIN_REG = 2'b00,
        RPR_WIN_STD = 2'b01,
        RPR_WIN_ALT = 2'b10
    } rpr_win_t;

endpackage

// ==== rtl/rpr_ram.sv ====
// 256 x 8 extension ram with registered read data
`timescale 1ns/1ps
module rpr_ram (
    input  wire logic       mclk,
    input  wire logic       ce,
    input  wire logic       we,
    input  wire logic       re,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata
);
    logic [7:0] mem [0:255];

    // contents have no reset: they are kept across battery operation
    always_ff @(posedge mclk) begin
        if (ce && we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (ce && re) begin
            rdata <= mem[addr];
        end
    end
endmodule // rpr_ram

// ==== rtl/rpr_regs.sv ====
// power-control, identification and extension-ram register group
`timescale 1ns/1ps
module rpr_regs #(
    parameter rpr_pkg::rpr_ident_t IDENT = '{
        part_high: 8'h5A, part_low: 8'hA5,        // arbitrary identity values
        rev_major: 5'h01, rev_minor: 3'h0,
        fab_year: 4'h0, fab_week: 6'h00, wafer: 6'h00,
        lot: 2'h0, quadrant: 6'h00, serial: 8'h00}
) (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic              ce,
    input  wire rpr_pkg::rpr_req_t req,
    output logic            [7:0]  rdata,
    output logic                   rvalid,
    input  wire logic              bat_above_thr_raw,
    input  wire logic              bat_above_min_raw,
    input  wire logic              main_above_pu_raw,
    input  wire logic              on_battery_raw,
    input  wire logic              watchdog_kick_pin,
    input  wire logic              external_interrupt_pin,
    input  wire logic              clkout_core,
    output logic                   interface_enable,
    output logic                   kick_input_gated,
    output logic                   ext_irq_input_gated,
    output logic                   clock_out_irq3_pin,
    output logic                   clock_out_irq3_oe_n,
    output logic                   battery_low_flag
);
    // ------------------------------------------------------------
    // input synchronisers (three stages, change counts when last two agree)
    // ------------------------------------------------------------
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] stable_q;

    assign raw_in = {bat_above_thr_raw, bat_above_min_raw, main_above_pu_raw,
                     on_battery_raw, watchdog_kick_pin, external_interrupt_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge arst_n) begin
                if (!arst_n) begin
                    s1_q[gi]     <= 1'b0;
                    s2_q[gi]     <= 1'b0;
                    s3_q[gi]     <= 1'b0;
                    stable_q[gi] <= 1'b0;
                end else if (ce) begin
                    s1_q[gi] <= raw_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        stable_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    logic bat_thr;
    logic bat_min;
    logic main_pu;
    logic on_bat;
    logic kick_lvl;
    logic ext_lvl;
    assign {bat_thr, bat_min, main_pu, on_bat, kick_lvl, ext_lvl} = stable_q;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic rpr_pkg::rpr_win_t win_of(input logic [7:0] a);
        if (a >= rpr_pkg::OFF_ALT_RAM_LO) begin
            win_of = rpr_pkg::RPR_WIN_ALT;
        end else if (a >= rpr_pkg::OFF_STD_RAM_LO) begin
            win_of = rpr_pkg::RPR_WIN_STD;
        end else begin
            win_of = rpr_pkg::RPR_WIN_REG;
        end
    endfunction

    rpr_pkg::rpr_win_t win;
    logic wr_reg;
    logic unlocked;
    assign win      = win_of(req.addr);
    assign wr_reg   = req.wr && (win == rpr_pkg::RPR_WIN_REG);

    // ------------------------------------------------------------
    // configuration key
    // ------------------------------------------------------------
    logic [7:0] key_q;
    assign unlocked = (key_q == rpr_pkg::KEY_ANALOG_UNLOCK);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            key_q <= rpr_pkg::RST_CFG_KEY;
        end else if (ce && req.wr) begin
            if (req.addr == rpr_pkg::OFF_CFG_KEY) begin
                key_q <= req.wdata;
            end else begin
                key_q <= rpr_pkg::RST_CFG_KEY;
            end
        end
    end

    // ------------------------------------------------------------
    // protected and control registers
    // ------------------------------------------------------------
    logic [7:0] bat_io_q;
    logic [7:0] gating_q;
    logic [7:0] page_q;

    // undefined bits are masked so stray ones from the host never stick
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bat_io_q <= rpr_pkg::RST_BATTERY_IO;
        end else if (ce && wr_reg && req.addr == rpr_pkg::OFF_BATTERY_IO && unlocked) begin
            bat_io_q <= req.wdata & rpr_pkg::MASK_BATTERY_IO;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gating_q <= rpr_pkg::RST_INPUT_GATING;
        end else if (ce && wr_reg && req.addr == rpr_pkg::OFF_INPUT_GATING && unlocked) begin
            gating_q <= req.wdata & rpr_pkg::MASK_INPUT_GATING;
        end
    end

    // pin-level bits are never stored, so host writes cannot touch them
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            page_q <= rpr_pkg::RST_RAM_PAGE;
        end else if (ce && wr_reg && req.addr == rpr_pkg::OFF_RAM_PAGE) begin
            page_q <= req.wdata & rpr_pkg::MASK_RAM_PAGE_RW;
        end
    end

    // ------------------------------------------------------------
    // power-mode gating outputs
    // ------------------------------------------------------------
    logic clk_en_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            interface_enable    <= 1'b1;
            kick_input_gated    <= 1'b0;
            ext_irq_input_gated <= 1'b0;
            clock_out_irq3_pin  <= 1'b0;
            clk_en_q            <= 1'b1;
        end else if (ce) begin
            interface_enable    <= !on_bat || bat_io_q[rpr_pkg::BIT_KEEP_IF];
            kick_input_gated    <= kick_lvl && (!on_bat || gating_q[rpr_pkg::BIT_KICK_BAT_EN]);
            ext_irq_input_gated <= ext_lvl && (!on_bat || gating_q[rpr_pkg::BIT_EXT_BAT_EN]);
            clock_out_irq3_pin  <= clkout_core;
            clk_en_q            <= !on_bat || page_q[rpr_pkg::BIT_CLKOUT_BAT_EN];
        end
    end
    assign clock_out_irq3_oe_n = !clk_en_q;

    // battery-low follows the comparator in the chosen direction
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            battery_low_flag <= 1'b0;
        end else if (ce) begin
            battery_low_flag <= page_q[rpr_pkg::BIT_BAT_LOW_POL] ? bat_thr : !bat_thr;
        end
    end

    // ------------------------------------------------------------
    // extension ram paging
    // ------------------------------------------------------------
    logic [7:0] ram_addr;
    logic       ram_we;
    logic       ram_re;
    logic       page_en;
    logic       alt_ok;
    assign page_en = page_q[rpr_pkg::BIT_PAGE_ENABLE];
    // alternate window is dead outside i2c mode: writes drop, reads give zero
    assign alt_ok  = (win == rpr_pkg::RPR_WIN_ALT) && req.i2c_mode;

    always_comb begin
        ram_addr = 8'h00;
        if (win == rpr_pkg::RPR_WIN_ALT) begin
            ram_addr = {page_en & page_q[rpr_pkg::BIT_ALT_PAGE], req.addr[6:0]};
        end else begin
            ram_addr = {page_en ? page_q[rpr_pkg::STD_PAGE_MSB:rpr_pkg::STD_PAGE_LSB] : 2'b00,
                        req.addr[5:0]};
        end
    end

    assign ram_we = req.wr && ((win == rpr_pkg::RPR_WIN_STD) || alt_ok);
    assign ram_re = req.rd && ((win == rpr_pkg::RPR_WIN_STD) || alt_ok);

    logic [7:0] ram_rdata;
    rpr_ram u_ram (
        .mclk  (mclk),
        .ce    (ce),
        .we    (ram_we),
        .re    (ram_re),
        .addr  (ram_addr),
        .wdata (req.wdata),
        .rdata (ram_rdata)
    );

    // ------------------------------------------------------------
    // read path: one cycle after rd
    // ------------------------------------------------------------
    logic [7:0] reg_rd;
    always_comb begin
        reg_rd = 8'h00;
        case (req.addr)
            rpr_pkg::OFF_CFG_KEY:       reg_rd = key_q;
            rpr_pkg::OFF_BATTERY_IO:    reg_rd = bat_io_q;
            rpr_pkg::OFF_PART_HIGH:     reg_rd = IDENT.part_high;
            rpr_pkg::OFF_PART_LOW:      reg_rd = IDENT.part_low;
            rpr_pkg::OFF_REVISION:      reg_rd = {IDENT.rev_major, IDENT.rev_minor};
            rpr_pkg::OFF_YEAR_WEEK:     reg_rd = {IDENT.fab_year, IDENT.fab_week[3:0]};
            rpr_pkg::OFF_WAFER_WEEK:    reg_rd = {IDENT.wafer, IDENT.fab_week[5:4]};
            rpr_pkg::OFF_LOT_QUAD:      reg_rd = {IDENT.lot, IDENT.quadrant};
            rpr_pkg::OFF_SERIAL:        reg_rd = IDENT.serial;
            rpr_pkg::OFF_SUPPLY_STATUS: reg_rd = {bat_thr, bat_min, 4'h0, main_pu, 1'b0};
            rpr_pkg::OFF_INPUT_GATING:  reg_rd = gating_q;
            rpr_pkg::OFF_RAM_PAGE:      reg_rd = {page_q[7:6], kick_lvl, ext_lvl, page_q[3:0]};
            default:                    reg_rd = 8'h00;
        endcase
    end

    logic       ram_sel_q;
    logic [7:0] reg_rd_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ram_sel_q <= 1'b0;
            reg_rd_q  <= 8'h00;
            rvalid    <= 1'b0;
        end else if (ce) begin
            rvalid <= req.rd;
            // read data stands until the next read, not just for the rvalid cycle
            if (req.rd) begin
                ram_sel_q <= ram_re;
                reg_rd_q  <= reg_rd;
            end
        end
    end
    assign rdata = ram_sel_q ? ram_rdata : reg_rd_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_key_load;
        req.wr && ce && req.addr == rpr_pkg::OFF_CFG_KEY && req.wdata == rpr_pkg::KEY_ANALOG_UNLOCK;
    endsequence
    sequence s_prot_wr;
        req.wr && ce && req.addr == rpr_pkg::OFF_BATTERY_IO;
    endsequence
    sequence s_gate_wr;
        req.wr && ce && req.addr == rpr_pkg::OFF_INPUT_GATING;
    endsequence
    // an idle cycle between key and protected write keeps the key armed
    sequence s_key_gap;
        s_key_load ##1 !(ce && req.wr);
    endsequence

    chk_batio_unlock_write: assert property (@(posedge mclk) disable iff (!arst_n)
        ((s_key_load ##1 s_prot_wr) or (s_key_gap ##1 s_prot_wr))
        |=> bat_io_q == ($past(req.wdata) & rpr_pkg::MASK_BATTERY_IO))
        else $error("battery io not written after key");
    chk_gating_unlock_write: assert property (@(posedge mclk) disable iff (!arst_n)
        ((s_key_load ##1 s_gate_wr) or (s_key_gap ##1 s_gate_wr))
        |=> gating_q == ($past(req.wdata) & rpr_pkg::MASK_INPUT_GATING))
        else $error("gating not written after key");
    chk_batio_locked: assert property (@(posedge mclk) disable iff (!arst_n)
        (s_prot_wr and (key_q != rpr_pkg::KEY_ANALOG_UNLOCK)) |=> $stable(bat_io_q))
        else $error("locked battery io write took effect");
    chk_gating_locked: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && req.wr && req.addr == rpr_pkg::OFF_INPUT_GATING && !unlocked) |=> $stable(gating_q))
        else $error("locked gating write took effect");
    chk_key_clear: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && req.wr && req.addr != rpr_pkg::OFF_CFG_KEY) |=> key_q == rpr_pkg::RST_CFG_KEY)
        else $error("key not cleared after write");
    chk_iface_keep: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && on_bat && bat_io_q[rpr_pkg::BIT_KEEP_IF]) |=> interface_enable)
        else $error("interface dropped on battery");
    chk_kick_gate: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && on_bat && !gating_q[rpr_pkg::BIT_KICK_BAT_EN]) |=> !kick_input_gated)
        else $error("kick input passed on battery");
    chk_ext_gate: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && on_bat && !gating_q[rpr_pkg::BIT_EXT_BAT_EN]) |=> !ext_irq_input_gated)
        else $error("ext irq passed on battery");
    chk_clkout_off: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && on_bat && !page_q[rpr_pkg::BIT_CLKOUT_BAT_EN]) |=> clock_out_irq3_oe_n)
        else $error("clock out driven on battery");
    chk_page_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        (!page_en && win != rpr_pkg::RPR_WIN_REG) |-> !ram_addr[7] && (win == rpr_pkg::RPR_WIN_ALT || !ram_addr[6]))
        else $error("upper ram address not zero");
    chk_std_window: assert property (@(posedge mclk) disable iff (!arst_n)
        (win == rpr_pkg::RPR_WIN_STD && page_en) |-> ram_addr == {page_q[1:0], req.addr[5:0]})
        else $error("standard window address wrong");
    chk_alt_i2c_only: assert property (@(posedge mclk) disable iff (!arst_n)
        (win == rpr_pkg::RPR_WIN_ALT && !req.i2c_mode) |-> !ram_we && !ram_re)
        else $error("alternate ram reached outside i2c");
    chk_status_read: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && req.rd && req.addr == rpr_pkg::OFF_SUPPLY_STATUS) |=> rdata[7] == $past(bat_thr))
        else $error("status bit 7 wrong");
    chk_status_min: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && req.rd && req.addr == rpr_pkg::OFF_SUPPLY_STATUS) |=> rdata[6] == $past(bat_min))
        else $error("status bit 6 wrong");
    chk_status_main: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && req.rd && req.addr == rpr_pkg::OFF_SUPPLY_STATUS) |=> rdata[1] == $past(main_pu))
        else $error("status bit 1 wrong");
    chk_pin_levels: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && req.rd && req.addr == rpr_pkg::OFF_RAM_PAGE) |=> rdata[5:4] == {$past(kick_lvl), $past(ext_lvl)})
        else $error("pin level bits wrong");
    chk_part_number: assert property (@(posedge mclk) disable iff (!arst_n)
        (ce && req.rd && req.addr == rpr_pkg::OFF_PART_HIGH) |=> rdata == IDENT.part_high)
        else $error("part number high wrong");
    chk_batlow_follow: assert property (@(posedge mclk) disable iff (!arst_n)
        ce |=> battery_low_flag == ($past(page_q[rpr_pkg::BIT_BAT_LOW_POL]) ? $past(bat_thr) : !$past(bat_thr)))
        else $error("battery low flag wrong");
endmodule // rpr_regs

// ==== tb/rpr_host.sv ====
// host-side model of the serial front end issuing register requests
`timescale 1ns/1ps
module rpr_host (
    input  wire logic              mclk,
    output rpr_pkg::rpr_req_t      req,
    input  wire logic        [7:0] rdata,
    input  wire logic              rvalid
);
    // ------------------------------------------------------------
    // bus tasks
    // ------------------------------------------------------------
    initial req = '0;

    // released data lines show the inverse so a stale byte cannot pass
    task automatic wr(input logic [7:0] addr, input logic [7:0] data, input logic i2c);
        logic [7:0] d;
        d = (addr == rpr_pkg::OFF_BATTERY_IO) ? (data & rpr_pkg::MASK_BATTERY_IO) : data;
        @(posedge mclk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d, i2c_mode: i2c};
        @(posedge mclk);
        req.wr    <= 1'b0;
        req.wdata <= ~d;
    endtask

    // the key must be the last write before the protected write; reads in between leave it armed
    task automatic pwr(input logic [7:0] addr, input logic [7:0] data);
        wr(rpr_pkg::OFF_CFG_KEY, rpr_pkg::KEY_ANALOG_UNLOCK, 1'b1);
        wr(addr, data, 1'b1);
    endtask

    task automatic rd(input logic [7:0] addr, input logic i2c, output logic [7:0] data);
        logic got;
        got  = 1'b0;
        data = 8'hXX;
        @(posedge mclk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00, i2c_mode: i2c};
        @(posedge mclk);
        req.rd <= 1'b0;
        for (int i = 0; i < 4 && !got; i++) begin
            @(posedge mclk);
            if (rvalid === 1'b1) begin
                data = rdata;
                got  = 1'b1;
            end
        end
    endtask
endmodule // rpr_host

// ==== tb/rpr_regs_test.sv ====
// self-checking bench for the power, identification and ram register group
`timescale 1ns/1ps
module rpr_regs_test;
    // ------------------------------------------------------------
    // signals and design
    // ------------------------------------------------------------
    // identity values are arbitrary
    localparam rpr_pkg::rpr_ident_t ID = '{part_high: 8'h3C, part_low: 8'hC3, rev_major: 5'h0B, rev_minor: 3'h5,
        fab_year: 4'h6, fab_week: 6'h2D, wafer: 6'h15, lot: 2'h2, quadrant: 6'h2A, serial: 8'h96};
    logic               mclk   = 1'b0;
    logic               arst_n = 1'b0;
    logic               ce     = 1'b1;
    logic               onbat  = 1'b0;
    logic               thr    = 1'b0;
    logic               battery_above_minimum   = 1'b0;
    logic               mainpu = 1'b0;
    logic               kick   = 1'b0;
    logic               ext    = 1'b0;
    logic               clkc   = 1'b0;
    rpr_pkg::rpr_req_t  req;
    logic         [7:0] rdata;
    logic               rvalid, if_en, kick_g, ext_g, co_pin, co_oe_n, bl;
    logic         [7:0] seed   = 8'h54;
    logic         [7:0] mem [256];
    logic         [7:0] idb [7];
    logic       [255:0] vld    = '0;
    logic         [7:0] bio, gat, pg, v, a, d;
    int                 fail_count = 0;
    int                 n_tests    = 0;
    int                 cycles     = 0;

    always #25 mclk = ~mclk;

    rpr_regs #(.IDENT(ID)) u_rpr_regs (.mclk(mclk), .arst_n(arst_n), .ce(ce), .req(req), .rdata(rdata),
        .rvalid(rvalid), .bat_above_thr_raw(thr), .bat_above_min_raw(battery_above_minimum), .main_above_pu_raw(mainpu),
        .on_battery_raw(onbat), .watchdog_kick_pin(kick), .external_interrupt_pin(ext), .clkout_core(clkc),
        .interface_enable(if_en), .kick_input_gated(kick_g), .ext_irq_input_gated(ext_g),
        .clock_out_irq3_pin(co_pin), .clock_out_irq3_oe_n(co_oe_n), .battery_low_flag(bl));
    rpr_host u_rpr_host (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));

    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction

    // physical ram byte behind a window offset for a given page register
    function automatic logic [7:0] phys(input logic [7:0] p, input logic [7:0] adr);
        if (adr[7]) begin
            return {p[3] & p[2], adr[6:0]};
        end
        return {p[3] ? p[1:0] : 2'b00, adr[5:0]};
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rc(input logic [7:0] adr, input logic i2c, input logic [7:0] exp, input string what);
        logic [7:0] got;
        u_rpr_host.rd(adr, i2c, got);
        chk(what, exp, got);
    endtask

    task automatic do_reset();
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (16) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (6) @(posedge mclk);  // pin synchronisers need a few edges
    endtask

    task automatic reset_vals();
        rc(8'h1F, 1'b1, 8'h00, "key");
        rc(8'h27, 1'b1, 8'h80, "battery_io");
        rc(8'h30, 1'b1, 8'h00, "gating");
        rc(8'h3F, 1'b1, {2'b00, kick, ext, 4'h0}, "page");
    endtask

    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        idb = '{ID.part_high, ID.part_low, {ID.rev_major, ID.rev_minor}, {ID.fab_year, ID.fab_week[3:0]},
                {ID.wafer, ID.fab_week[5:4]}, {ID.lot, ID.quadrant}, ID.serial};
        do_reset();
        reset_vals();
        for (int i = 0; i < 7; i++) begin
            u_rpr_host.wr(8'h28 + 8'(i), rnd(), 1'b1);
            rc(8'h28 + 8'(i), 1'b1, idb[i], "ident");
        end
        // no key, then key with a read between, then a key made stale by another write
        u_rpr_host.wr(8'h27, 8'h00, 1'b1);
        rc(8'h27, 1'b1, 8'h80, "battery_io");
        u_rpr_host.wr(8'h1F, 8'h9D, 1'b1);
        rc(8'h1F, 1'b1, 8'h9D, "key");
        u_rpr_host.wr(8'h27, 8'h00, 1'b1);
        rc(8'h27, 1'b1, 8'h00, "battery_io");
        rc(8'h1F, 1'b1, 8'h00, "key");
        u_rpr_host.wr(8'h1F, 8'h9D, 1'b1);
        u_rpr_host.wr(8'h3F, 8'h00, 1'b1);
        u_rpr_host.wr(8'h30, 8'hC0, 1'b1);
        rc(8'h30, 1'b1, 8'h00, "gating");
        ce <= 1'b0;
        u_rpr_host.wr(8'h3F, 8'hCF, 1'b1);
        ce <= 1'b1;
        rc(8'h3F, 1'b1, {2'b00, kick, ext, 4'h0}, "page_frozen");
        for (int c = 0; c < 4; c++) begin
            bio = (c == 0) ? 8'h00 : (c == 1) ? 8'hFF : rnd();
            gat = (c == 0) ? 8'h00 : (c == 1) ? 8'hFF : rnd();
            pg  = (c == 0) ? 8'h00 : (c == 1) ? 8'hFF : rnd();
            u_rpr_host.pwr(8'h27, bio);
            u_rpr_host.pwr(8'h30, gat);
            u_rpr_host.wr(8'h3F, pg, 1'b1);
            rc(8'h27, 1'b1, bio & 8'h80, "battery_io");
            rc(8'h30, 1'b1, gat & 8'hC0, "gating");
            for (int j = 0; j < 6; j++) begin
                v = rnd();
                {clkc, ext, kick, mainpu, battery_above_minimum, thr, onbat} <= v[6:0];
                u_rpr_host.wr(8'h2F, rnd(), 1'b1);
                repeat (6) @(posedge mclk);
                #1;
                chk("if_en", {7'h00, ~onbat | bio[7]}, {7'h00, if_en});
                chk("kick_g", {7'h00, kick & (~onbat | gat[7])}, {7'h00, kick_g});
                chk("ext_g", {7'h00, ext & (~onbat | gat[6])}, {7'h00, ext_g});
                chk("co_oe_n", {7'h00, onbat & ~pg[7]}, {7'h00, co_oe_n});
                chk("bat_low", {7'h00, pg[6] ? thr : ~thr}, {7'h00, bl});
                if (!(onbat & ~pg[7])) begin
                    chk("co_pin", {7'h00, clkc}, {7'h00, co_pin});
                end
                rc(8'h2F, 1'b1, {thr, battery_above_minimum, 4'h0, mainpu, 1'b0}, "status");
                rc(8'h3F, 1'b1, {pg[7:6], kick, ext, pg[3:0]}, "page");
            end
        end
        do_reset();
        reset_vals();
        // few offsets, many pages, so both windows often land on one byte
        for (int k = 0; k < 48; k++) begin
            pg = rnd() & 8'h0F;
            u_rpr_host.wr(8'h3F, pg, 1'b1);
            v = rnd();
            a = (v & 8'hC3) | 8'h40;
            d = rnd();
            u_rpr_host.wr(a, d, v[2]);
            if (!a[7] || v[2]) begin
                mem[phys(pg, a)] = d;
                vld[phys(pg, a)] = 1'b1;
            end
            a = (rnd() & 8'hC3) | 8'h40;
            v = rnd();
            if (a[7] && !v[0]) begin
                rc(a, 1'b0, 8'h00, "alt_spi");
            end else if (vld[phys(pg, a)]) begin
                rc(a, v[0], mem[phys(pg, a)], "ram");
            end
        end
        end_of_test();
    end
endmodule // rpr_regs_test
